// >>> bench/battery_charge_sequencer_asserts.sv
// port assertions for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_asserts
	import charger_pkg::*;
#(
	parameter int WD_INTERVAL = WD_INTERVAL_CYCLES
)
(
	input wire logic       clk_in,                      // clock
	input wire logic       rst_in,                      // reset
	input wire logic       adapter_present_shutdown_in, // line
	input wire logic       input_limit_in,              // limiting
	input wire logic       current_below_c10_in,        // low current
	input wire logic       overvoltage_in,              // overvoltage
	input wire logic       top_gate_drive_out,          // top
	input wire logic       bottom_gate_drive_out,       // bottom
	input wire logic       charge_enable_out,           // enable
	input wire logic       trickle_out,                 // trickle
	input wire logic       charge_status_out,           // pin value
	input wire logic       charge_status_oe_out,        // strong
	input wire logic       charge_status_weak_out,      // weak
	input wire logic       temp_fault_out,              // temp fault
	input wire logic       c10_latch_out,               // latch
	input wire chg_state_t state_out                    // state
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	logic [15:0] top_run_q;
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !top_gate_drive_out)
			top_run_q <= 16'h0;
		else
			top_run_q <= top_run_q + 16'h1;
	end
	ovp_gates_off_a: assert property (
		overvoltage_in |-> ##2 !(top_gate_drive_out || bottom_gate_drive_out))
		else $error("drive on in overvoltage");
	limit_bottom_a: assert property (
		input_limit_in && current_below_c10_in |-> ##2 !bottom_gate_drive_out)
		else $error("bottom on while limiting");
	c10_inhibit_a: assert property (
		$rose(c10_latch_out) |-> !$past(input_limit_in, 2))
		else $error("latch set while limiting");
	line_low_a: assert property (
		!adapter_present_shutdown_in |->
		##[1:3] !(charge_enable_out || c10_latch_out))
		else $error("no shutdown on line low");
	status_levels_a: assert property (
		!(charge_status_oe_out && charge_status_weak_out) && !charge_status_out)
		else $error("bad status level");
	weak_after_latch_a: assert property (
		$rose(c10_latch_out) |-> ##[0:2] charge_status_weak_out)
		else $error("no weak sink");
	temp_pause_a: assert property (
		temp_fault_out |-> ##[0:2] !charge_enable_out)
		else $error("charging in temp fault");
	idle_off_a: assert property (
		state_out inside {ST_MSD, ST_SD} && $stable(state_out)
		|-> !(charge_enable_out || trickle_out))
		else $error("current in shutdown");
	dropout_wd_a: assert property (
		int'(top_run_q) <= WD_INTERVAL + 3)
		else $error("top on too long");
	cover property ($rose(c10_latch_out));
	cover property (state_out == ST_COND ##1 state_out == ST_SD);
	cover property ($fell(top_gate_drive_out) && !overvoltage_in);
endmodule : battery_charge_sequencer_asserts
`default_nettype wire

// >>> bench/battery_charge_sequencer_tb.sv
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_tb;
	import charger_pkg::*;
	localparam int TT = 64;
	localparam int WD = 20;
	localparam int ST = 0, EN = 1, TF = 2, TP = 3, CL = 4, SM = 5;
	logic        clk_in = 1'b0;
	logic        rst_in, adp, uv_ok, line_hi, lim, ovp, t_req, b_req;
	logic        t_lo, t_hi, load, defeat, c25, c39, ilow, pin_lo;
	logic        top, bot, en, trk, s_pin, s_oe, s_wk, smp, tf, c10, flt, done;
	logic [12:0] mv;
	logic [1:0]  pin;
	chg_state_t  state;
	int          bad_count = 0;
	int          samples_checked = 0;

	always #2 clk_in = ~clk_in;

	battery_charge_sequencer #(
		.BASE_CYCLES(1), .TIMER_TICKS(TT), .WD_INTERVAL(WD)
	) battery_charge_sequencer_inst (
		.clk_in(clk_in), .rst_in(rst_in), .adapter_input_above_in(adp),
		.undervoltage_ok_in(uv_ok), .adapter_present_shutdown_in(line_hi),
		.cell_below_2v5_in(c25), .cell_below_3v9_in(c39),
		.current_below_c10_in(ilow), .input_limit_in(lim),
		.overvoltage_in(ovp), .charge_status_in(pin_lo),
		.top_request_in(t_req), .bottom_request_in(b_req),
		.therm_above_low_in(t_lo), .therm_below_high_in(t_hi),
		.top_gate_drive_out(top), .bottom_gate_drive_out(bot),
		.charge_enable_out(en), .trickle_out(trk), .charge_status_out(s_pin),
		.charge_status_oe_out(s_oe), .charge_status_weak_out(s_wk),
		.sample_switch_out(smp), .temp_fault_out(tf), .state_out(state),
		.c10_latch_out(c10), .fault_out(flt), .done_out(done)
	);
	battery_host_model battery_host_model_inst (
		.clk_in(clk_in), .load_in(load), .load_mv_in(mv), .charge_in(en),
		.trickle_in(trk), .strong_in(s_oe), .weak_in(s_wk), .defeat_in(defeat),
		.below_2v5_out(c25), .below_3v9_out(c39), .i_low_out(ilow),
		.pin_low_out(pin_lo), .pin_read_out(pin)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	function automatic logic [1:0] pick(input int i);
		case (i)
			ST: pick = state;
			EN: pick = {1'b0, en};
			TF: pick = {1'b0, tf};
			TP: pick = {1'b0, top};
			CL: pick = {1'b0, c10};
			default: pick = {1'b0, smp};
		endcase
	endfunction : pick

	// counts falling edges while (watched == v) matches stay; bounded
	task automatic span(input int i, input logic [1:0] v, input bit stay,
		input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge clk_in);
			n++;
		end
		while ((pick(i) === v) == stay && n < lim);
		if ((pick(i) === v) == stay)
		begin
			bad_count++;
			$display("FAIL t=%0t wait %0d seen=%h", $time, i, pick(i));
			wrap_up();
		end
	endtask : span

	task automatic t_cond();
		int n;
		span(ST, ST_COND, 0, 10, n);
		span(SM, 1, 1, 2600, n);
		span(SM, 0, 1, 20, n);
		check(n, HOLD_TICKS);
		span(TF, 1, 1, 4, n);
		span(EN, 0, 1, 4, n);
		check({trk, s_oe, pin}, 4'hc);
		span(ST, ST_COND, 1, 40, n);
		check({state, flt, en, s_oe, s_wk, pin}, 8'h62);
		repeat (10) @(negedge clk_in);
		check(state, ST_SD);
		@(posedge clk_in);
		line_hi <= 1'b0;
		load <= 1'b1;
		mv <= 13'h960;
		repeat (4) @(negedge clk_in);
		check({flt, done, en}, 3'h0);
		@(posedge clk_in);
		line_hi <= 1'b1;
		load <= 1'b0;
		span(ST, ST_COND, 0, 12, n);
		@(posedge clk_in);
		load <= 1'b1;
		mv <= 13'hbb8;
		@(posedge clk_in);
		load <= 1'b0;
		span(ST, ST_CHARGE, 0, 8, n);
		check({trk, pin}, 3'h0);
		$display("conditioning test end");
	endtask : t_cond

	task automatic t_c10();
		int n;
		@(posedge clk_in);
		load <= 1'b1;
		mv <= 13'h1040;
		lim <= 1'b1;
		b_req <= 1'b1;
		@(posedge clk_in);
		load <= 1'b0;
		repeat (6) @(negedge clk_in);
		check({c10, bot}, 2'h0);
		@(posedge clk_in);
		lim <= 1'b0;
		span(CL, 0, 1, 6, n);
		check({s_oe, s_wk, pin}, 4'h5);
		span(ST, ST_CHARGE, 1, 30, n);
		check(n >= 14 && n <= 19, 1'b1);
		check({done, en, pin}, 4'ha);
		@(posedge clk_in);
		load <= 1'b1;
		mv <= 13'hed8;
		@(posedge clk_in);
		load <= 1'b0;
		span(ST, ST_CHARGE, 0, 8, n);
		check({done, c10}, 2'h0);
		span(ST, ST_CHARGE, 1, 80, n);
		check(n >= TT - 2 && n <= TT + 3, 1'b1);
		@(posedge clk_in);
		defeat <= 1'b1;
		span(ST, ST_CHARGE, 0, 8, n);
		repeat (100) @(negedge clk_in);
		check(state, ST_CHARGE);
		$display("tenth current test end");
	endtask : t_c10

	task automatic t_gates();
		int n;
		@(posedge clk_in);
		t_req <= 1'b1;
		ovp <= 1'b1;
		repeat (4) @(negedge clk_in);
		check({top, bot}, 2'h0);
		@(posedge clk_in);
		ovp <= 1'b0;
		span(TP, 0, 1, 6, n);
		span(TP, 1, 1, WD + 4, n);
		check(n <= WD, 1'b1);
		span(TP, 0, 1, 90, n);
		check(n >= WD_OFF_CYCLES - 1 && n <= WD_OFF_CYCLES + 1, 1'b1);
		@(posedge clk_in);
		t_req <= 1'b0;
		$display("gate drive test end");
	endtask : t_gates

	task automatic t_therm();
		int n;
		@(posedge clk_in);
		t_lo <= 1'b0;
		span(SM, 1, 1, 2600, n);
		span(SM, 0, 1, 20, n);
		span(TF, 0, 1, 4, n);
		check({state, en}, {ST_CHARGE, 1'b0});
		span(SM, 1, 1, 2600, n);
		// one edge of the window went to the fault check
		check(n + 1, SAMPLE_TICKS);
		@(posedge clk_in);
		t_lo <= 1'b1;
		span(SM, 0, 1, 20, n);
		span(TF, 1, 1, 4, n);
		span(EN, 0, 1, 4, n);
		$display("thermistor test end");
	endtask : t_therm

	task automatic t_undervoltage_lockout();
		int n;
		@(posedge clk_in);
		defeat <= 1'b0;
		uv_ok <= 1'b0;
		span(ST, ST_CHARGE, 1, 6, n);
		check({state, en, s_oe, s_wk}, 5'h08);
		$display("lockout test end");
	endtask : t_undervoltage_lockout

	task automatic t_lowbat();
		int n;
		@(posedge clk_in);
		uv_ok <= 1'b1;
		load <= 1'b1;
		mv <= 13'hbb8;
		span(ST, ST_CHARGE, 0, 8, n);
		@(posedge clk_in);
		mv <= 13'h7d0;
		@(posedge clk_in);
		load <= 1'b0;
		span(ST, ST_CHARGE, 1, 30, n);
		check(n >= TT / 4 && n <= TT / 4 + 4, 1'b1);
		check({flt, c10, done, en, pin}, 6'h2a);
		$display("low cell test end");
	endtask : t_lowbat

	initial
	begin
		{rst_in, adp, uv_ok, line_hi, t_lo, t_hi, load} = 7'h7f;
		{lim, ovp, t_req, b_req, defeat} = 5'h0;
		mv = 13'h7d0;
		repeat (4) @(negedge clk_in);
		check({state, smp, tf, en, s_oe, s_wk, top, bot, c10}, 10'h0c0);
		@(posedge clk_in);
		rst_in <= 1'b0;
		load <= 1'b0;
		t_cond();
		t_c10();
		t_gates();
		t_therm();
		t_undervoltage_lockout();
		t_lowbat();
		wrap_up();
	end
endmodule : battery_charge_sequencer_tb

bind battery_charge_sequencer battery_charge_sequencer_asserts #(
	.WD_INTERVAL(WD_INTERVAL)
) checker_inst (
	.clk_in(clk_in), .rst_in(rst_in),
	.adapter_present_shutdown_in(adapter_present_shutdown_in),
	.input_limit_in(input_limit_in),
	.current_below_c10_in(current_below_c10_in),
	.overvoltage_in(overvoltage_in),
	.top_gate_drive_out(top_gate_drive_out),
	.bottom_gate_drive_out(bottom_gate_drive_out),
	.charge_enable_out(charge_enable_out), .trickle_out(trickle_out),
	.charge_status_out(charge_status_out),
	.charge_status_oe_out(charge_status_oe_out),
	.charge_status_weak_out(charge_status_weak_out),
	.temp_fault_out(temp_fault_out), .c10_latch_out(c10_latch_out),
	.state_out(state_out)
);
`default_nettype wire

// >>> bench/battery_host_model.sv
// battery, switch and host model facing the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module battery_host_model
(
	input  wire logic        clk_in,        // clock
	input  wire logic        load_in,       // load cell voltage
	input  wire logic [12:0] load_mv_in,    // mV per cell
	input  wire logic        charge_in,     // current allowed
	input  wire logic        trickle_in,    // tenth current
	input  wire logic        strong_in,     // strong sink
	input  wire logic        weak_in,       // weak sink
	input  wire logic        defeat_in,     // host defeats timer
	output logic             below_2v5_out, // cell low
	output logic             below_3v9_out, // cell under restart
	output logic             i_low_out,     // taper current
	output logic             pin_low_out,   // host holds pin
	output logic [1:0]       pin_read_out   // 0 strong 1 weak 2 off
);
	logic [12:0] mv_q;
	always_ff @(posedge clk_in)
	begin
		if (load_in)
			mv_q <= load_mv_in;
		else if (charge_in && !trickle_in && mv_q < 13'h1068)
			mv_q <= mv_q + 13'h1; // trickle rise too slow to matter
	end
	assign below_2v5_out = mv_q < 13'h9c4;
	assign below_3v9_out = mv_q < 13'hf3c;
	assign i_low_out = charge_in && mv_q >= 13'h1036;
	assign pin_low_out = defeat_in;
	// two pull-ups let the host tell three levels apart
	assign pin_read_out = strong_in ? 2'h0 : (weak_in ? 2'h1 : 2'h2);
endmodule : battery_host_model
`default_nettype wire

// >>> hdl/battery_charge_sequencer.sv
// charge state sequencer, timers, status pin and gate drive gating
//
// Overview of operation
// - lockout low: shutdown, current off, timer reset
// - depleted cell: conditioning at tenth current, status low
// - conditioning past quarter period: fault shutdown, release
// - shutdown line low: shutdown, clear latch, reset
// - thermistor fault: stop charging, pause timer, keep status
// - current under tenth: set latch, reset timer, weak sink
// - terminate at quarter if latched, else full
// - low cell while charging: fault after quarter period
// - tenth-current detect inhibited during input limiting
// - low current while limiting forces bottom drive off
// - overvoltage turns both drives off until clear
// - dropout watchdog forces top off periodically
// - sampler: sample 127.5x20 periods, hold 10
// - register temperature fault at end of hold
// - temperature fault shuts charger, suspends timer
// - timer period is 10 times 2^27 base periods
// - status: strong low, weak sink, or released
// - after termination restart below 3.9V per cell
// - start only with input, lockout and line high
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer
	import charger_pkg::*;
#(
	parameter int BASE_CYCLES  = BASE_CYCLES_DEF,
	parameter int TIMER_TICKS  = TIMER_TICKS_DEF,
	parameter int WD_INTERVAL  = WD_INTERVAL_CYCLES
)
(
	input  wire logic clk_in,                 // clock
	input  wire logic rst_in,                 // sync reset, high
	input  wire logic adapter_input_above_in, // input above sense node
	input  wire logic undervoltage_ok_in,     // input above lockout level
	input  wire logic adapter_present_shutdown_in, // line high, not forced
	input  wire logic cell_below_2v5_in,      // cell under 2.5V per cell
	input  wire logic cell_below_3v9_in,      // cell under 3.9V per cell
	input  wire logic current_below_c10_in,   // current under tenth
	input  wire logic input_limit_in,         // input current limiting
	input  wire logic overvoltage_in,         // battery overvoltage
	input  wire logic charge_status_in,       // status pin forced low
	input  wire logic top_request_in,         // pwm wants top switch on
	input  wire logic bottom_request_in,      // pwm wants bottom on
	input  wire logic therm_above_low_in,     // thermistor above low limit
	input  wire logic therm_below_high_in,    // thermistor below high limit
	output logic      top_gate_drive_out,     // top switch on
	output logic      bottom_gate_drive_out,  // bottom switch on
	output logic      charge_enable_out,      // battery current allowed
	output logic      trickle_out,            // tenth-current setting
	output logic      charge_status_out,      // status pin level, always 0
	output logic      charge_status_oe_out,   // strong pull-down on
	output logic      charge_status_weak_out, // weak sink on
	output logic      sample_switch_out,      // thermistor sample switch
	output logic      temp_fault_out,         // temperature fault flag
	output chg_state_t state_out,             // sequencer state
	output logic      c10_latch_out,          // tenth-current latch
	output logic      fault_out,              // low-battery fault
	output logic      done_out                // terminated, awaiting restart
);

	localparam logic [TIMER_W-1:0] FULL_W    = TIMER_W'(TIMER_TICKS);
	localparam logic [TIMER_W-1:0] QUARTER_W = TIMER_W'(TIMER_TICKS / 4);
	localparam logic [TICK_W-1:0]  TICK_LAST = TICK_W'(BASE_CYCLES - 1);
	localparam logic [WD_W-1:0]    WD_LAST   = WD_W'(WD_INTERVAL - 1);
	localparam logic [WDOFF_W-1:0] WD_OFF_W  = WDOFF_W'(WD_OFF_CYCLES);

	core_t core_q;
	core_t core_d;
	sens_t sens_now;
	logic  temp_fault;

	function automatic logic is_active(input chg_state_t st);
		is_active = (st == ST_COND) || (st == ST_CHARGE);
	endfunction : is_active

	always_comb
	begin
		sens_now.adapter_above    = adapter_input_above_in;
		sens_now.undervoltage_lockout_ok          = undervoltage_ok_in;
		sens_now.acp_high         = adapter_present_shutdown_in;
		sens_now.cell_lt_2v5      = cell_below_2v5_in;
		sens_now.cell_lt_3v9      = cell_below_3v9_in;
		sens_now.i_lt_c10         = current_below_c10_in;
		sens_now.in_limit         = input_limit_in;
		sens_now.ovp              = overvoltage_in;
		sens_now.defeat           = charge_status_in;
		sens_now.top_req          = top_request_in;
		sens_now.bot_req          = bottom_request_in;
		sens_now.therm_above_low  = therm_above_low_in;
		sens_now.therm_below_high = therm_below_high_in;
	end

	thermistor_sampler thermistor_sampler_inst (
		.clk_in            (clk_in),
		.rst_in            (rst_in),
		.tick_in           (core_q.tick),
		.above_low_in      (core_q.in.therm_above_low),
		.below_high_in     (core_q.in.therm_below_high),
		.sample_switch_out (sample_switch_out),
		.temp_fault_out    (temp_fault)
	);

	always_comb
	begin
		sens_t i;
		logic  ready;
		logic  tmr_clr;
		logic  tmr_run;
		logic  wd_force;
		logic  en;
		i        = core_q.in;
		ready    = 1'b0;
		tmr_clr  = 1'b0;
		tmr_run  = 1'b0;
		wd_force = 1'b0;
		en       = 1'b0;
		core_d   = core_q;
		core_d.in   = sens_now;
		core_d.tick = 1'b0;

		// base-period tick from the timing clock
		if (core_q.tick_cnt == TICK_LAST)
		begin
			core_d.tick_cnt = '0;
			core_d.tick     = 1'b1;
		end
		else
			core_d.tick_cnt = core_q.tick_cnt + 1'b1;

		ready = i.adapter_above & i.undervoltage_lockout_ok & i.acp_high;

		case (core_q.st)
			ST_MSD:
			begin
				if (i.adapter_above)
					core_d.st = ST_SD;
			end
			ST_SD:
			begin
				if (ready && !core_q.done && !core_q.lock)
				begin
					tmr_clr = 1'b1;
					core_d.fault = 1'b0;
					if (i.cell_lt_2v5)
						core_d.st = ST_COND;
					else
						core_d.st = ST_CHARGE;
				end
				else if (ready && core_q.done && !i.cell_lt_2v5 &&
					i.cell_lt_3v9)
				begin
					core_d.st    = ST_CHARGE;
					core_d.done  = 1'b0;
					core_d.lock  = 1'b0;
					// a restart begins a fresh cycle, latch cleared
					core_d.c10   = 1'b0;
					core_d.fault = 1'b0;
					tmr_clr      = 1'b1;
				end
				// a depleted cell after a low-battery fault stays here
			end
			ST_COND:
			begin
				tmr_run = ~temp_fault;
				if (!i.cell_lt_2v5)
					core_d.st = ST_CHARGE;
				else if (!i.defeat && core_q.timer >= QUARTER_W)
				begin
					core_d.st    = ST_SD;
					core_d.fault = 1'b1;
					core_d.lock  = 1'b1;
					core_d.done  = 1'b1;
					tmr_clr      = 1'b1;
				end
			end
			ST_CHARGE:
			begin
				tmr_run = ~temp_fault;
				if (!core_q.c10 && i.i_lt_c10 && !i.in_limit &&
					!temp_fault)
				begin
					core_d.c10 = 1'b1;
					tmr_clr    = 1'b1;
				end
				if (i.cell_lt_2v5 && !temp_fault)
					core_d.lowbat = core_q.lowbat + 1'b1;
				else if (!i.cell_lt_2v5)
					core_d.lowbat = '0;
				if (core_q.lowbat >= QUARTER_W)
				begin
					core_d.st    = ST_SD;
					core_d.fault = 1'b1;
					core_d.lock  = 1'b1;
					core_d.done  = 1'b1;
					core_d.c10   = 1'b0;
					tmr_clr      = 1'b1;
				end
				else if (!i.defeat &&
					(core_q.c10 ? core_q.timer >= QUARTER_W
					            : core_q.timer >= FULL_W))
				begin
					core_d.st   = ST_SD;
					core_d.done = 1'b1;
					tmr_clr     = 1'b1;
				end
			end
			default:
				core_d.st = ST_MSD;
		endcase

		// the low-cell counter only counts ticks while charging
		if (core_q.st != ST_CHARGE || !core_q.tick)
			if (core_d.lowbat != core_q.lowbat && core_q.st == ST_CHARGE)
				core_d.lowbat = core_q.lowbat;
		if (core_q.st != ST_CHARGE || core_d.st != ST_CHARGE)
			core_d.lowbat = '0;

		// adapter loss overrides all states; lockout and forced shutdown override all but ST_MSD
		if (!i.adapter_above)
		begin
			core_d.st    = ST_MSD;
			core_d.c10   = 1'b0;
			core_d.done  = 1'b0;
			core_d.lock  = 1'b0;
			core_d.fault = 1'b0;
			tmr_clr      = 1'b1;
		end
		else if (!i.undervoltage_lockout_ok && core_q.st != ST_MSD)
		begin
			core_d.st = ST_SD;
			tmr_clr   = 1'b1;
		end
		else if (!i.acp_high && core_q.st != ST_MSD)
		begin
			core_d.st    = ST_SD;
			core_d.c10   = 1'b0;
			core_d.done  = 1'b0;
			core_d.lock  = 1'b0;
			core_d.fault = 1'b0;
			tmr_clr      = 1'b1;
		end

		// saturating so a defeated timer cannot wrap
		if (tmr_clr)
			core_d.timer = '0;
		else if (tmr_run && core_q.tick && core_q.timer != FULL_W)
			core_d.timer = core_q.timer + 1'b1;

		// dropout watchdog on a continuous top request
		if (core_q.wd_off != '0)
		begin
			wd_force       = 1'b1;
			core_d.wd_off  = core_q.wd_off - 1'b1;
			core_d.wd_cnt  = '0;
		end
		else if (i.top_req)
		begin
			if (core_q.wd_cnt == WD_LAST)
			begin
				core_d.wd_cnt = '0;
				core_d.wd_off = WD_OFF_W;
			end
			else
				core_d.wd_cnt = core_q.wd_cnt + 1'b1;
		end
		else
			core_d.wd_cnt = '0;

		en = is_active(core_d.st) & ~temp_fault;
		core_d.enable  = en;
		core_d.trickle = (core_d.st == ST_COND);
		core_d.top = i.top_req & en & ~i.ovp & ~wd_force;
		core_d.bot = i.bot_req & en & ~i.ovp &
			~(i.in_limit & i.i_lt_c10);
		core_d.stat_strong = is_active(core_d.st) & ~core_d.c10;
		core_d.stat_weak   = is_active(core_d.st) & core_d.c10;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			core_q <= '{st: ST_MSD, default: '0};
		else
			core_q <= core_d;
	end

	assign top_gate_drive_out     = core_q.top;
	assign bottom_gate_drive_out  = core_q.bot;
	assign charge_enable_out      = core_q.enable;
	assign trickle_out            = core_q.trickle;
	assign charge_status_out      = 1'b0;
	assign charge_status_oe_out   = core_q.stat_strong;
	assign charge_status_weak_out = core_q.stat_weak;
	assign temp_fault_out         = temp_fault;
	assign state_out              = core_q.st;
	assign c10_latch_out          = core_q.c10;
	assign fault_out              = core_q.fault;
	assign done_out               = core_q.done;

endmodule : battery_charge_sequencer
`default_nettype wire

// >>> hdl/charger_pkg.sv
// shared constants and types for the battery charge sequencer
package charger_pkg;

	// clock rate
	localparam int CLK_PERIOD_PS      = 4000;

	// dropout watchdog: forced top-off time and interval
	localparam int WD_OFF_NS          = 300;
	localparam int WD_OFF_CYCLES      =
		(WD_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WD_INTERVAL_US     = 40;
	localparam int WD_INTERVAL_CYCLES =
		(WD_INTERVAL_US * 1000000) / CLK_PERIOD_PS;

	// base period of the timing-resistor clock, in clk cycles
	localparam int BASE_CYCLES_DEF    = 25;

	// thermistor sampler: sample = 127.5 * 20 base periods, hold = 10
	localparam int SAMPLE_X10         = 1275;
	localparam int SAMPLE_MULT        = 20;
	localparam int SAMPLE_TICKS       = SAMPLE_X10 * SAMPLE_MULT / 10;
	localparam int HOLD_TICKS         = 10;

	// termination timer: 10 * 2**27 base periods
	localparam int TIMER_MULT         = 10;
	localparam int TIMER_EXP          = 27;
	localparam int TIMER_TICKS_DEF    = TIMER_MULT * (2 ** TIMER_EXP);

	// counter widths
	localparam int TIMER_W            = 31;
	localparam int WD_W               = 14;
	localparam int WDOFF_W            = 7;
	localparam int TICK_W             = 12;
	localparam int SMP_W              = 12;

	typedef enum logic [1:0] {
		ST_MSD,
		ST_SD,
		ST_COND,
		ST_CHARGE
	} chg_state_t;

	// comparator and pin levels, registered once on entry
	typedef struct packed {
		logic adapter_above;
		logic undervoltage_lockout_ok;
		logic acp_high;
		logic cell_lt_2v5;
		logic cell_lt_3v9;
		logic i_lt_c10;
		logic in_limit;
		logic ovp;
		logic defeat;
		logic top_req;
		logic bot_req;
		logic therm_above_low;
		logic therm_below_high;
	} sens_t;

	typedef struct packed {
		logic             sampling;
		logic [SMP_W-1:0] cnt;
		logic             fault;
	} smp_t;

	typedef struct packed {
		sens_t              in;
		logic [TICK_W-1:0]  tick_cnt;
		logic               tick;
		chg_state_t         st;
		logic [TIMER_W-1:0] timer;
		logic [TIMER_W-1:0] lowbat;
		logic               c10;
		logic               done;
		logic               lock;
		logic               fault;
		logic [WD_W-1:0]    wd_cnt;
		logic [WDOFF_W-1:0] wd_off;
		logic               top;
		logic               bot;
		logic               enable;
		logic               trickle;
		logic               stat_strong;
		logic               stat_weak;
	} core_t;

endpackage : charger_pkg

// >>> hdl/thermistor_sampler.sv
// thermistor sample-and-hold sequencer with temperature-fault flag
`timescale 1ns/1ps
`default_nettype none
module thermistor_sampler
	import charger_pkg::*;
(
	input  wire logic clk_in,            // clock
	input  wire logic rst_in,            // sync reset, high
	input  wire logic tick_in,           // one base period elapsed
	input  wire logic above_low_in,      // sensed voltage above low limit
	input  wire logic below_high_in,     // sensed voltage below high limit
	output logic      sample_switch_out, // sample switch closed
	output logic      temp_fault_out     // temperature out of window
);

	localparam logic [SMP_W-1:0] SAMPLE_LAST = SMP_W'(SAMPLE_TICKS - 1);
	localparam logic [SMP_W-1:0] HOLD_LAST   = SMP_W'(HOLD_TICKS - 1);

	smp_t smp_q;
	smp_t smp_d;

	always_comb
	begin
		smp_d = smp_q;
		if (tick_in)
		begin
			if (smp_q.sampling)
			begin
				if (smp_q.cnt == SAMPLE_LAST)
				begin
					smp_d.sampling = 1'b0;
					smp_d.cnt      = '0;
				end
				else
					smp_d.cnt = smp_q.cnt + 1'b1;
			end
			else if (smp_q.cnt == HOLD_LAST)
			begin
				smp_d.sampling = 1'b1;
				smp_d.cnt      = '0;
				smp_d.fault    = ~(above_low_in & below_high_in);
			end
			else
				smp_d.cnt = smp_q.cnt + 1'b1;
		end
	end

	// fault starts set: no charging before the first qualified reading
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			smp_q.sampling <= 1'b1;
			smp_q.cnt      <= '0;
			smp_q.fault    <= 1'b1;
		end
		else
			smp_q <= smp_d;
	end

	assign sample_switch_out = smp_q.sampling;
	assign temp_fault_out    = smp_q.fault;

endmodule : thermistor_sampler
`default_nettype wire
